/* File: verilog/olt_pkg.sv */
// olt_pkg: constants and types for the local information tlv codec.
// assumes one 100 MHz clock domain and a plain register port with 8-bit
// byte addresses and 32-bit data.
package olt_pkg;

  // tlv framing
  localparam logic [7:0]  TYPE_END     = 8'h00;  // end of tlv list marker
  localparam logic [7:0]  TYPE_LOCAL   = 8'h01;  // local information tlv
  localparam logic [7:0]  LOCAL_LEN    = 8'h10;  // fixed tlv length, 16 octets
  localparam logic [7:0]  OAM_VERSION  = 8'h01;  // protocol version one
  localparam logic [7:0]  MIN_TLV_LEN  = 8'h02;  // type plus length octets
  localparam int          TLV_OCTETS   = 16;     // octets per tlv

  // size limits in octets
  localparam int          MIN_FRAME    = 64;     // minimum frame size
  localparam int          MAX_BASIC    = 1518;   // maximum basic frame size
  localparam int          SIZE_DIV     = 8;      // divisor for the floor

  // register byte addresses
  localparam logic [7:0]  ADR_CFG      = 8'h00;  // mux, parser, capabilities
  localparam logic [7:0]  ADR_MAXSZ    = 8'h04;  // local maximum pdu size
  localparam logic [7:0]  ADR_OUI      = 8'h08;  // organization identifier
  localparam logic [7:0]  ADR_VENDOR   = 8'h0C;  // vendor information
  localparam logic [7:0]  ADR_STATUS   = 8'h10;  // revision, limit, flags
  localparam logic [7:0]  ADR_RSTATE   = 8'h14;  // peer revision, state, caps
  localparam logic [7:0]  ADR_RMAXSZ   = 8'h18;  // peer maximum pdu size
  localparam logic [7:0]  ADR_ROUI     = 8'h1C;  // peer identifier
  localparam logic [7:0]  ADR_RVENDOR  = 8'h20;  // peer vendor information
  localparam logic [7:0]  ADR_CMD      = 8'h24;  // bit 0 sends one tlv

  // field positions
  localparam int          CFG_PAR_LSB  = 0;      // parser action, 2 bits
  localparam int          CFG_MUX_BIT  = 2;      // multiplexer action
  localparam int          CFG_CAP_LSB  = 8;      // capabilities, 5 bits
  localparam int          ST_LIMIT_LSB = 16;     // negotiated limit, 11 bits
  localparam int          ST_NEG_BIT   = 27;     // negotiation done
  localparam int          ST_SKIP_BIT  = 28;     // last peer tlv unchanged
  localparam int          RS_STATE_LSB = 16;     // peer state octet
  localparam int          RS_CAP_LSB   = 24;     // peer capability octet
  localparam int          CMD_SEND_BIT = 0;      // start transmit

  // reset values and the reserved parser code
  localparam logic [1:0]  PAR_FWD      = 2'h0;   // forward upward
  localparam logic [1:0]  PAR_RSVD     = 2'h3;   // reserved parser code
  localparam logic [4:0]  CAP_RST      = 5'h00;  // no capabilities, passive
  localparam logic [23:0] OUI_RST      = 24'h000000;   // arbitrary
  localparam logic [31:0] VENDOR_RST   = 32'h00000000; // arbitrary

  // local information tlv, first octet in the top bits
  typedef struct packed {
    logic [7:0]  tlv_type;   // information type
    logic [7:0]  tlv_len;    // tlv length
    logic [7:0]  version;    // protocol version
    logic [15:0] revision;   // revision counter
    logic [7:0]  state;      // mux and parser actions
    logic [7:0]  caps;       // capability and mode bits
    logic [15:0] max_size;   // maximum pdu size
    logic [23:0] oui;        // organization identifier
    logic [31:0] vendor;     // vendor information
  } olt_tlv_t;

  // local content that the revision counter tracks
  typedef struct packed {
    logic        mux;        // multiplexer action
    logic [1:0]  par;        // parser action
    logic [4:0]  caps;       // capabilities
    logic [10:0] max_size;   // maximum pdu size
    logic [23:0] oui;        // organization identifier
    logic [31:0] vendor;     // vendor information
  } olt_info_t;

endpackage

/* File: verilog/olt_codec.sv */
// olt_codec: builds the local information tlv for transmission, parses the
// peer's tlv list and negotiates the maximum pdu size.
// assumes the receive byte stream comes from logic on the same clock and the
// transmit consumer takes one octet per cycle while tx_valid is high.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module olt_codec #(
  parameter int MIN_FRAME = olt_pkg::MIN_FRAME,  // minimum frame size
  parameter int MAX_BASIC = olt_pkg::MAX_BASIC   // maximum basic frame size
) (
  input  wire logic        clock,     // 100 MHz clock
  input  wire logic        rstn,      // asynchronous reset, active low
  input  wire logic [7:0]  addr,      // register byte address
  input  wire logic [31:0] wdata,     // register write data
  input  wire logic        wr,        // write strobe
  input  wire logic        rd,        // read strobe
  output logic      [31:0] rdata,     // read data, cycle after rd
  input  wire logic        rx_valid,  // received octet valid
  input  wire logic [7:0]  rx_data,   // received octet
  input  wire logic        rx_start,  // octet is the first tlv type
  input  wire logic        rx_last,   // octet is the last of the frame
  output logic             tx_valid,  // transmit octet valid
  output logic      [7:0]  tx_data,   // transmit octet
  output logic             tx_last,   // last octet of the tlv
  output logic      [10:0] tx_limit   // octet limit for outgoing pdus
);

  localparam logic [10:0] SIZE_FLOOR = 11'(MIN_FRAME / olt_pkg::SIZE_DIV);
  localparam logic [10:0] SIZE_CEIL  = 11'(MAX_BASIC);

  // the size field has only eleven bits and the floor may not sit above the ceiling
  // refused while elaborating, so a bad window never reaches silicon
  if (MAX_BASIC > 2047 || MIN_FRAME < olt_pkg::SIZE_DIV ||
      MIN_FRAME / olt_pkg::SIZE_DIV > MAX_BASIC) begin : g_bad_size
    $error("olt_codec: size parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // local configuration registers

  olt_pkg::olt_info_t loc_r;        // local tlv content
  olt_pkg::olt_info_t loc_prev_r;   // content at last revision step
  logic [15:0]        rev_r;        // local revision counter
  logic               wr_cfg;       // write to the config register
  logic               wr_size;      // write to the size register
  logic [10:0]        size_req;     // requested size from software
  logic [10:0]        size_clamp;   // requested size forced into range

  assign wr_cfg   = wr && addr == olt_pkg::ADR_CFG;
  assign wr_size  = wr && addr == olt_pkg::ADR_MAXSZ;
  assign size_req = wdata[10:0];

  // software may not advertise outside the legal window, so clamp it
  always_comb begin
    if (size_req < SIZE_FLOOR) begin
      size_clamp = SIZE_FLOOR;
    end else if (size_req > SIZE_CEIL) begin
      size_clamp = SIZE_CEIL;
    end else begin
      size_clamp = size_req;
    end
  end

  // config writes; a reserved parser code leaves the old action in place
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loc_r.mux      <= 1'b0;
      loc_r.par      <= olt_pkg::PAR_FWD;
      loc_r.caps     <= olt_pkg::CAP_RST;
      loc_r.max_size <= SIZE_CEIL;
      loc_r.oui      <= olt_pkg::OUI_RST;
      loc_r.vendor   <= olt_pkg::VENDOR_RST;
    end else begin
      if (wr_cfg) begin
        loc_r.mux  <= wdata[olt_pkg::CFG_MUX_BIT];
        loc_r.caps <= wdata[olt_pkg::CFG_CAP_LSB +: 5];
        if (wdata[olt_pkg::CFG_PAR_LSB +: 2] != olt_pkg::PAR_RSVD) begin
          loc_r.par <= wdata[olt_pkg::CFG_PAR_LSB +: 2];
        end
      end
      if (wr_size) begin
        loc_r.max_size <= size_clamp;
      end
      if (wr && addr == olt_pkg::ADR_OUI) begin
        loc_r.oui <= wdata[23:0];
      end
      if (wr && addr == olt_pkg::ADR_VENDOR) begin
        loc_r.vendor <= wdata;
      end
    end
  end

  // revision steps once for each cycle in which content has moved; a write
  // of the same value is not a change and leaves the revision alone
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rev_r               <= 16'h0000;
      loc_prev_r.mux      <= 1'b0;
      loc_prev_r.par      <= olt_pkg::PAR_FWD;
      loc_prev_r.caps     <= olt_pkg::CAP_RST;
      loc_prev_r.max_size <= SIZE_CEIL;
      loc_prev_r.oui      <= olt_pkg::OUI_RST;
      loc_prev_r.vendor   <= olt_pkg::VENDOR_RST;
    end else if (loc_r != loc_prev_r) begin
      rev_r      <= rev_r + 16'h0001;
      loc_prev_r <= loc_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit serializer

  olt_pkg::olt_tlv_t tlv_img;     // assembled tlv image
  logic [127:0]      tx_shift_r;  // octets still to send
  logic [3:0]        tx_cnt_r;    // index of octet on tx_data
  logic              tx_go;       // start request

  // field order and reserved zeros; version and length are constants
  always_comb begin
    tlv_img          = '0;
    tlv_img.tlv_type = olt_pkg::TYPE_LOCAL;
    tlv_img.tlv_len  = olt_pkg::LOCAL_LEN;
    tlv_img.version  = olt_pkg::OAM_VERSION;
    tlv_img.revision = rev_r;
    tlv_img.state    = {5'h00, loc_r.mux, loc_r.par};
    tlv_img.caps     = {3'h0, loc_r.caps};
    tlv_img.max_size = {5'h00, loc_r.max_size};
    tlv_img.oui      = loc_r.oui;
    tlv_img.vendor   = loc_r.vendor;
  end

  // a start while a tlv is going out is ignored rather than queued
  assign tx_go = wr && addr == olt_pkg::ADR_CMD && wdata[olt_pkg::CMD_SEND_BIT] && !tx_valid;

  // snapshot the image so a config write mid-tlv cannot tear the octets
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      tx_last    <= 1'b0;
      tx_cnt_r   <= 4'h0;
      tx_shift_r <= '0;
    end else if (tx_go) begin
      tx_valid   <= 1'b1;
      tx_data    <= tlv_img[127:120];
      tx_shift_r <= {tlv_img[119:0], 8'h00};
      tx_cnt_r   <= 4'h0;
      tx_last    <= 1'b0;
    end else if (tx_valid && !tx_last) begin
      tx_data    <= tx_shift_r[127:120];
      tx_shift_r <= {tx_shift_r[119:0], 8'h00};
      tx_cnt_r   <= tx_cnt_r + 4'h1;
      tx_last    <= tx_cnt_r == 4'(olt_pkg::TLV_OCTETS - 2);
    end else begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive parser

  typedef enum logic [1:0] {RX_IDLE, RX_TYPE, RX_BODY} olt_rx_t;

  olt_rx_t            rx_st_r;     // parser state
  logic [7:0]         rx_type_r;   // type of current tlv
  logic [7:0]         rx_len_r;    // length of current tlv
  logic [7:0]         rx_idx_r;    // index of next octet in the tlv
  logic [119:0]       rx_cap_r;    // captured octets of the tlv
  olt_pkg::olt_tlv_t  rx_img;      // tlv image with the final octet
  logic               rx_done;     // local tlv fully received
  logic               rem_vld_r;   // a peer tlv has been taken
  logic               skip_r;      // last peer tlv was unchanged
  logic [15:0]        rem_rev_r;   // peer revision
  logic               rem_mux_r;   // peer multiplexer action
  logic [1:0]         rem_par_r;   // peer parser action
  logic [4:0]         rem_caps_r;  // peer capabilities
  logic [10:0]        rem_size_r;  // peer maximum size
  logic [23:0]        rem_oui_r;   // peer identifier
  logic [31:0]        rem_vend_r;  // peer vendor information

  assign rx_img  = {rx_cap_r, rx_data};
  // a longer tlv still carries the expected fields in its first sixteen octets
  // the closing octet of a frame is never data, so a tlv ending there is cut
  assign rx_done = rx_valid && !rx_last && rx_st_r == RX_BODY &&
                   rx_type_r == olt_pkg::TYPE_LOCAL &&
                   rx_len_r >= olt_pkg::LOCAL_LEN &&
                   rx_idx_r == 8'(olt_pkg::TLV_OCTETS - 1);

  // walk the tlv list; a short tlv or the end marker stops it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_st_r   <= RX_IDLE;
      rx_type_r <= olt_pkg::TYPE_END;
      rx_len_r  <= 8'h00;
      rx_idx_r  <= 8'h00;
      rx_cap_r  <= '0;
    end else if (rx_valid) begin
      rx_cap_r <= {rx_cap_r[111:0], rx_data};
      if (rx_last) begin
        rx_st_r <= RX_IDLE;  // a tlv cut by the frame end is dropped
      end else if (rx_start || rx_st_r == RX_TYPE) begin
        rx_type_r <= rx_data;
        rx_idx_r  <= 8'h01;
        rx_st_r   <= (rx_data == olt_pkg::TYPE_END) ? RX_IDLE : RX_BODY;
      end else begin
        unique case (rx_st_r)
          RX_IDLE: begin
            rx_st_r <= RX_IDLE;  // wait for the next list
          end
          RX_BODY: begin
            rx_idx_r <= rx_idx_r + 8'h01;
            if (rx_idx_r == 8'h01) begin
              rx_len_r <= rx_data;
              if (rx_data < olt_pkg::MIN_TLV_LEN) begin
                rx_st_r <= RX_IDLE;
              end else if (rx_data == olt_pkg::MIN_TLV_LEN) begin
                rx_st_r <= RX_TYPE;
              end
            end else if (rx_idx_r == rx_len_r - 8'h01) begin
              rx_st_r <= RX_TYPE;
            end
          end
          default: begin
            rx_st_r <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // take the peer fields; same revision means nothing changed, skip it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rem_vld_r  <= 1'b0;
      skip_r     <= 1'b0;
      rem_rev_r  <= 16'h0000;
      rem_mux_r  <= 1'b0;
      rem_par_r  <= olt_pkg::PAR_FWD;
      rem_caps_r <= 5'h00;
      rem_size_r <= 11'h000;
      rem_oui_r  <= 24'h000000;
      rem_vend_r <= 32'h00000000;
    end else if (rx_done) begin
      if (rem_vld_r && rx_img.revision == rem_rev_r) begin
        skip_r <= 1'b1;
      end else begin
        skip_r     <= 1'b0;
        rem_vld_r  <= 1'b1;
        rem_rev_r  <= rx_img.revision;
        rem_mux_r  <= rx_img.state[2];
        rem_caps_r <= rx_img.caps[4:0];
        rem_size_r <= rx_img.max_size[10:0];
        rem_oui_r  <= rx_img.oui;
        rem_vend_r <= rx_img.vendor;
        if (rx_img.state[1:0] != olt_pkg::PAR_RSVD) begin
          rem_par_r <= rx_img.state[1:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // size negotiation

  logic [10:0] lim_min;  // smaller of the two sizes

  always_comb begin
    lim_min = (rem_size_r < loc_r.max_size) ? rem_size_r : loc_r.max_size;
  end

  // a peer below the floor cannot push the limit under it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_limit <= SIZE_FLOOR;
    end else if (!rem_vld_r) begin
      tx_limit <= SIZE_FLOOR;
    end else begin
      tx_limit <= (lim_min < SIZE_FLOOR) ? SIZE_FLOOR : lim_min;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read port

  // unmapped addresses read as zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      unique case (addr)
        olt_pkg::ADR_CFG:     rdata <= {19'h0, loc_r.caps, 5'h00, loc_r.mux, loc_r.par};
        olt_pkg::ADR_MAXSZ:   rdata <= {21'h0, loc_r.max_size};
        olt_pkg::ADR_OUI:     rdata <= {8'h00, loc_r.oui};
        olt_pkg::ADR_VENDOR:  rdata <= loc_r.vendor;
        olt_pkg::ADR_STATUS:  rdata <= {3'h0, skip_r, rem_vld_r, tx_limit, rev_r};
        olt_pkg::ADR_RSTATE:  rdata <= {3'h0, rem_caps_r, 5'h00, rem_mux_r, rem_par_r,
                                        rem_rev_r};
        olt_pkg::ADR_RMAXSZ:  rdata <= {21'h0, rem_size_r};
        olt_pkg::ADR_ROUI:    rdata <= {8'h00, rem_oui_r};
        olt_pkg::ADR_RVENDOR: rdata <= rem_vend_r;
        default:              rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  a_tx_length: assert property (@(posedge clock) disable iff (!rstn)
    tx_go |=> ##1 (tx_cnt_r == 4'h1 && tx_data == 8'h10))
    else $error("length octet is not sixteen");

  a_tx_version: assert property (@(posedge clock) disable iff (!rstn)
    tx_go |=> ##2 (tx_data == 8'h01))
    else $error("version octet is not one");

  a_state_rsvd: assert property (@(posedge clock) disable iff (!rstn)
    (tx_valid && tx_cnt_r == 4'h5) |-> (tx_data[7:3] == 5'h00 && tx_data[1:0] != 2'h3))
    else $error("state octet carries reserved bits or code 11");

  a_caps_rsvd: assert property (@(posedge clock) disable iff (!rstn)
    (tx_valid && tx_cnt_r == 4'h6) |-> (tx_data[7:5] == 3'h0))
    else $error("capability octet carries reserved bits");

  a_tx_frame: assert property (@(posedge clock) disable iff (!rstn)
    tx_go |=> (tx_valid && tx_data == 8'h01) ##15 (tx_valid && tx_last) ##1 !tx_valid)
    else $error("tlv is not sixteen octets starting with type one");

  a_rev_step: assert property (@(posedge clock) disable iff (!rstn)
    (rev_r != $past(rev_r)) |-> (rev_r == $past(rev_r) + 16'h0001))
    else $error("revision moved by other than one");

  a_size_range: assert property (@(posedge clock) disable iff (!rstn)
    wr_size |=> (loc_r.max_size >= SIZE_FLOOR && loc_r.max_size <= SIZE_CEIL))
    else $error("advertised size outside legal window");

  a_pre_limit: assert property (@(posedge clock) disable iff (!rstn)
    !rem_vld_r |=> (tx_limit == SIZE_FLOOR))
    else $error("limit above floor before agreement");

  a_neg_limit: assert property (@(posedge clock) disable iff (!rstn)
    (rem_vld_r && $stable(rem_size_r) && $stable(loc_r.max_size)) |->
      (tx_limit <= loc_r.max_size && (tx_limit <= rem_size_r || tx_limit == SIZE_FLOOR)))
    else $error("limit exceeds the smaller size");

  a_rx_par: assert property (@(posedge clock) disable iff (!rstn)
    (rx_done && rx_img.state[1:0] == 2'h3) |=> $stable(rem_par_r))
    else $error("reserved peer parser code was taken");

endmodule

/* File: dv/olt_peer.sv */
// olt_peer: remote oam peer that feeds tlv octets into the codec.
// assumes the codec samples the rx lines on the rising clock edge.
`timescale 1ns/1ps
module olt_peer (
  input  wire logic       clock,     // shared clock
  output logic            rx_valid,  // octet valid
  output logic      [7:0] rx_data,   // octet
  output logic            rx_start,  // first type octet
  output logic            rx_last    // closing octet
);
  logic [7:0] last_r = 8'h5A;  // last octet driven

  initial begin
    rx_valid = 1'b0;
    rx_start = 1'b0;
    rx_last  = 1'b0;
    rx_data  = 8'hA5;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one octet for one cycle
  task automatic put(input logic [7:0] d, input logic s, input logic l);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data  <= d;
    rx_start <= s;
    rx_last  <= l;
    last_r   <= d;
  endtask

  // a released line shows the inverse so a stale octet never looks valid
  task automatic idle();
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_start <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~last_r;
  endtask

  // optional end marker, tlv msb first, then one closing octet never parsed
  task automatic send(input olt_pkg::olt_tlv_t t, input bit end_first, input bit slow);
    logic [127:0] v;
    int           i;
    v = t;
    if (end_first) begin
      put(8'h00, 1'b1, 1'b0);
      put(8'h02, 1'b0, 1'b0);  // legal length, so only the type can stop the list
    end
    for (i = 15; i >= 0; i--) begin
      put(v[i*8 +: 8], (i == 15) && !end_first, 1'b0);
      if (slow)
        idle();
    end
    put(~last_r, 1'b0, 1'b1);
    idle();
  endtask
endmodule

/* File: dv/olt_codec_tb.sv */
// olt_codec_tb: self-checking bench for the local information tlv codec.
// assumes default size parameters and the olt_peer model on the rx side.
`timescale 1ns/1ps
module olt_codec_tb;
  logic               clock;           // 100 MHz
  logic               rstn;            // reset, active low
  logic        [7:0]  addr;            // register address
  logic       [31:0]  wdata;           // write data
  logic               wr;              // write strobe
  logic               rd;              // read strobe
  logic       [31:0]  rdata;           // read data
  logic               rx_valid;        // peer octet valid
  logic        [7:0]  rx_data;         // peer octet
  logic               rx_start;        // peer first octet
  logic               rx_last;         // peer closing octet
  logic               tx_valid;        // sent octet valid
  logic        [7:0]  tx_data;         // sent octet
  logic               tx_last;         // last sent octet
  logic       [10:0]  tx_limit;        // negotiated limit
  logic               rd_d = 1'b0;     // read answer due
  int                 err_total = 0;   // mismatches
  int                 num_checks = 0;  // comparisons
  int                 i;               // loop index
  logic       [31:0]  rd_q[$];         // expected read words
  logic        [8:0]  tx_q[$];         // expected {last, octet}
  logic       [15:0]  lrev = 16'h0;    // expected local revision
  logic       [31:0]  pst;             // expected peer state word
  olt_pkg::olt_info_t cur;             // expected local content
  olt_pkg::olt_info_t nxt;             // content after a write
  olt_pkg::olt_tlv_t  pt;              // tlv the peer sends

  olt_codec u_olt_codec (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_start(rx_start),
    .rx_last(rx_last), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_limit(tx_limit));
  olt_peer u_olt_peer (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_start(rx_start), .rx_last(rx_last));

  ////////////////////////////////////////////////////////////////////////////
  // comparisons and verdict
  task automatic note(input bit bad, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (bad) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    note(g !== e, g, e);
  endtask
  task automatic cmp_tx(input logic [8:0] g, input logic [8:0] e);
    note(g !== e, {23'h0, g}, {23'h0, e});
  endtask
  task automatic cmp_lim(input logic [10:0] g, input logic [10:0] e);
    note(g !== e, {21'h0, g}, {21'h0, e});
  endtask
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // register bus: one-cycle strobes, a gap cycle between calls
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge clock);
    rd   <= 1'b0;
  endtask

  // any change of local content bumps the revision once
  task automatic set_info(input olt_pkg::olt_info_t n);
    if (n !== cur)
      lrev++;
    cur = n;
  endtask
  function automatic logic [31:0] status(input logic skip, input logic neg,
                                         input logic [10:0] lim);
    return {3'h0, skip, neg, lim, lrev};
  endfunction

  // sixteen octets expected from one send, reserved bits zero
  task automatic exp_tlv();
    logic [127:0] v;
    int           k;
    v = {8'h01, 8'h10, 8'h01, lrev, 5'h0, cur.mux, cur.par, 3'h0, cur.caps,
         5'h0, cur.max_size, cur.oui, cur.vendor};
    for (k = 15; k >= 0; k--)
      tx_q.push_back({k == 0, v[k*8 +: 8]});
  endtask

  // peer frame with reserved capability bits set
  task automatic frame(input logic [15:0] rv, input logic [7:0] st, input logic [15:0] sz,
                       input bit end_first, input bit slow);
    pt = '{8'h01, 8'h10, 8'h01, rv, st, 8'hE0 | 8'($urandom), sz, 24'($urandom), $urandom};
    u_olt_peer.send(pt, end_first, slow);
    repeat (3) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // monitor: results are taken where they have settled
  always @(posedge clock) rd_d <= rd;
  always @(negedge clock) begin
    if (rd_d === 1'b1)
      cmp_rd(rdata, rd_q.size() ? rd_q.pop_front() : 32'hDEADBEEF);
    if (tx_valid !== 1'b0)
      cmp_tx({tx_last, tx_data}, tx_q.size() ? tx_q.pop_front() : 9'h1FF);
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // watchdog far beyond the run of about 210 cycles
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {addr, wdata, wr, rd, rstn} = '0;
    cur = '{1'b0, 2'h0, 5'h00, 11'h5EE, 24'h0, 32'h0};
    void'($urandom(32'h8d45f485));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(8'h10, status(1'b0, 1'b0, 11'h008));
    rd_reg(8'h04, 32'h000005EE);
    rd_reg(8'h30, 32'h0);
    // every parser code, the reserved one last
    for (i = 0; i < 4; i++) begin
      nxt = cur;
      nxt.caps = 5'($urandom);
      nxt.mux = i[0];
      if (i != 3)
        nxt.par = i[1:0];
      wr_reg(8'h00, {19'h0, nxt.caps, 5'h0, i[0], i[1:0]});
      set_info(nxt);
      rd_reg(8'h00, {19'h0, cur.caps, 5'h0, cur.mux, cur.par});
    end
    nxt.max_size = 11'h008;
    wr_reg(8'h04, 32'h00000005);
    set_info(nxt);
    rd_reg(8'h04, 32'h00000008);
    nxt.max_size = 11'h258;
    wr_reg(8'h04, 32'h00000258);
    set_info(nxt);
    nxt.oui = 24'($urandom);
    wr_reg(8'h08, {8'h0, nxt.oui});
    set_info(nxt);
    nxt.vendor = $urandom;
    wr_reg(8'h0C, nxt.vendor);
    set_info(nxt);
    rd_reg(8'h10, status(1'b0, 1'b0, 11'h008));
    @(negedge clock);
    cmp_lim(tx_limit, 11'h008);
    // a second request while sending is dropped
    wr_reg(8'h24, 32'h1);
    exp_tlv();
    wr_reg(8'h24, 32'h1);
    repeat (20) @(posedge clock);
    frame(16'h0005, 8'hFD, 16'hF92C, 1'b0, 1'b0);
    pst = {3'h0, pt.caps[4:0], 5'h0, 3'h5, 16'h0005};
    @(negedge clock);
    cmp_lim(tx_limit, 11'h12C);
    rd_reg(8'h14, pst);
    rd_reg(8'h18, 32'h0000012C);
    rd_reg(8'h1C, {8'h0, pt.oui});
    rd_reg(8'h20, pt.vendor);
    rd_reg(8'h10, status(1'b0, 1'b1, 11'h12C));
    frame(16'h0005, 8'h02, 16'h0100, 1'b0, 1'b0);
    rd_reg(8'h10, status(1'b1, 1'b1, 11'h12C));
    rd_reg(8'h14, pst);
    frame(16'h0006, 8'h03, 16'h07D0, 1'b0, 1'b1);
    pst = {3'h0, pt.caps[4:0], 5'h0, 3'h1, 16'h0006};
    rd_reg(8'h14, pst);
    @(negedge clock);
    cmp_lim(tx_limit, 11'h258);
    frame(16'h0007, 8'h01, 16'h0010, 1'b1, 1'b0);
    rd_reg(8'h14, pst);
    wr_reg(8'h24, 32'h1);
    exp_tlv();
    repeat (20) @(posedge clock);
    cmp_rd(32'(rd_q.size() + tx_q.size()), 32'h0);
    wrap_up();
  end
endmodule
